//--- acs_chan_decode.v
// Purpose: Decodes the five-bit channel code into analog switch controls.
// Assumes: Purely combinational; the caller registers the outputs.
// Notes: Reserved and absent codes close no switch and raise the unimplemented flag.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"

module acs_chan_decode (
    input  wire [4:0]                 code,        // Channel select code.
    input  wire                       small_pkg,   // High on the smaller package.
    output reg  [`ACS_EXT_INPUTS-1:0] ext_sel,     // One-hot external input switches.
    output reg                        temp_sel,    // Temperature diode switch.
    output reg                        core_sel,    // Core supply rail switch.
    output reg                        bgap_sel,    // Band gap reference switch.
    output reg                        mux_open,    // All switches open.
    output reg                        unimpl       // Code selects no implemented input.
);

    // One switch at most is closed; every unlisted code leaves them all open.
    always @* begin
        ext_sel  = {`ACS_EXT_INPUTS{1'b0}};
        temp_sel = 1'b0;
        core_sel = 1'b0;
        bgap_sel = 1'b0;
        mux_open = 1'b0;
        unimpl   = 1'b0;
        if (code <= `ACS_CH_EXT_LAST) begin
            if (small_pkg && code >= `ACS_CH_SMALL_FIRST && code <= `ACS_CH_SMALL_LAST) begin
                unimpl = 1'b1;
            end else begin
                ext_sel[code[3:0]] = 1'b1;
            end
        end else begin
            case (code)
                `ACS_CH_DISCONNECT: mux_open = 1'b1;
                `ACS_CH_TEMP:       temp_sel = 1'b1;
                `ACS_CH_CORE:       core_sel = 1'b1;
                `ACS_CH_BANDGAP:    bgap_sel = 1'b1;
                default:            unimpl   = 1'b1;
            endcase
        end
    end

endmodule // acs_chan_decode
`default_nettype wire

//--- acs_channel_ctrl.v
// Purpose: Control register of the converter: channel select, conversion go flag and power-on bit.
// Assumes: The converter core shares clk and pulses conv_done with its result valid in that cycle.
// Notes: Registers sit on a plain strobe port with read data one cycle after the read strobe.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"

module acs_channel_ctrl (
    input  wire                        clk,             // System clock, 10 MHz.
    input  wire                        rstn,            // Synchronous reset, active low.
    input  wire [7:0]                  addr,            // Register byte address.
    input  wire [31:0]                 wr_data,         // Write data.
    input  wire                        wr_en,           // Write strobe.
    input  wire                        rd_en,           // Read strobe.
    output reg  [31:0]                 rd_data,         // Read data, valid the cycle after rd_en.
    input  wire                        small_pkg_pin,   // Package strap pin, asynchronous.
    input  wire                        conv_done,       // Converter core finished, one-cycle pulse.
    input  wire [`ACS_RESULT_WIDTH-1:0] conv_result,    // Converter core result.
    output reg                         conv_start,      // Start pulse to the converter core.
    output reg                         converter_enable,// Converter core power enable.
    output reg  [`ACS_EXT_INPUTS-1:0]  ain_switch,      // External input switch enables.
    output reg                         temp_diode_sel,  // Temperature diode switch.
    output reg                         core_rail_sel,   // Core supply rail switch.
    output reg                         bandgap_sel,     // Band gap reference switch.
    output reg                         mux_open,        // All multiplexer switches open.
    output reg                         chan_unimpl,     // Selected channel is not implemented.
    output reg                         irq              // Level interrupt.
);

    // The count is worked out at full width and cut to the counter's eight bits on purpose.
    localparam [31:0] ACQ_FULL   = `ACS_ACQ_CYCLES;
    localparam [7:0]  ACQ_CYCLES = ACQ_FULL[7:0];

    // Control state.
    reg  [4:0]                   input_channel_select;
    reg                          go_flag;
    reg                          converter_power_on;
    reg  [`ACS_RESULT_WIDTH-1:0] result;
    reg                          result_unpredictable;
    reg  [7:0]                   acq_count;
    reg                          acq_ready;

    // Strap synchroniser; only the second stage is read.
    reg                          small_meta;
    reg                          small_pkg;

    // Decoder outputs.
    wire [`ACS_EXT_INPUTS-1:0]   dec_ext;
    wire                         dec_temp;
    wire                         dec_core;
    wire                         dec_bgap;
    wire                         dec_open;
    wire                         dec_unimpl;
    wire                         start_unimpl;

    // Bus decode.
    wire                         ctrl_we;
    wire                         status_we;
    wire                         mask_we;
    wire [4:0]                   wr_chs;
    wire                         wr_on;
    wire                         start_req;
    wire                         done_take;
    wire [`ACS_EV_WIDTH-1:0]     events;
    wire [`ACS_EV_WIDTH-1:0]     irq_status;
    wire [`ACS_EV_WIDTH-1:0]     irq_mask;
    wire                         irq_level;
    wire [7:0]                   ctrl_read;
    reg  [31:0]                  next_rd_data;

    // Register strobes for each writable word.
    assign ctrl_we   = wr_en && (addr == `ACS_OFS_CTRL);
    assign status_we = wr_en && (addr == `ACS_OFS_STATUS);
    assign mask_we   = wr_en && (addr == `ACS_OFS_MASK);
    assign wr_chs    = wr_data[`ACS_CTRL_CHS_HI:`ACS_CTRL_CHS_LO];
    assign wr_on     = wr_data[`ACS_CTRL_ON_BIT];

    // A start needs the written power bit set and no conversion already running.
    assign start_req = ctrl_we && wr_data[`ACS_CTRL_GO_BIT] && wr_on && !go_flag;

    // Completion counts only while a conversion is actually outstanding and powered.
    assign done_take = conv_done && go_flag && converter_power_on;

    // Events: conversion finished, and a start issued on a code that selects no implemented input.
    assign events[`ACS_EV_DONE_BIT]  = done_take;
    assign events[`ACS_EV_BADCH_BIT] = start_req && start_unimpl;

    // Bit seven is not stored and reads as zero.
    assign ctrl_read = {1'b0, input_channel_select, go_flag, converter_power_on};

    // Strap pin crosses into the clock domain through two flops.
    always @(posedge clk) begin
        if (!rstn) begin
            small_meta <= 1'b0;
            small_pkg  <= 1'b0;
        end else begin
            small_meta <= small_pkg_pin;
            small_pkg  <= small_meta;
        end
    end

    // Channel decoding of the stored select code.
    acs_chan_decode u_decode (
        .code      (input_channel_select),
        .small_pkg (small_pkg),
        .ext_sel   (dec_ext),
        .temp_sel  (dec_temp),
        .core_sel  (dec_core),
        .bgap_sel  (dec_bgap),
        .mux_open  (dec_open),
        .unimpl    (dec_unimpl)
    );

    // The written code is decoded too, since a start converts that code and not the stored one.
    acs_chan_decode u_start_decode (
        .code      (wr_chs),
        .small_pkg (small_pkg),
        .ext_sel   (),
        .temp_sel  (),
        .core_sel  (),
        .bgap_sel  (),
        .mux_open  (),
        .unimpl    (start_unimpl)
    );

    // Control register; bit seven of the write data is simply dropped.
    always @(posedge clk) begin
        if (!rstn) begin
            input_channel_select <= `ACS_CHS_RESET;
            converter_power_on   <= 1'b0;
        end else if (ctrl_we) begin
            input_channel_select <= wr_chs;
            converter_power_on   <= wr_on;
        end
    end

    // Go flag: set by an accepted start, cleared by completion or loss of power.
    // Software writing zero to go does not abort; an abort only comes from power-off.
    always @(posedge clk) begin
        if (!rstn) begin
            go_flag    <= 1'b0;
            conv_start <= 1'b0;
        end else begin
            conv_start <= start_req;
            if (start_req) begin
                go_flag <= 1'b1;
            end else if (done_take) begin
                go_flag <= 1'b0;
            end else if (ctrl_we && !wr_on) begin
                go_flag <= 1'b0;
            end
        end
    end

    // Result capture; on an unimplemented code the core's value is kept as it comes.
    always @(posedge clk) begin
        if (!rstn) begin
            result               <= `ACS_RESULT_RESET;
            result_unpredictable <= 1'b0;
        end else begin
            if (start_req) begin
                result_unpredictable <= start_unimpl;
            end
            if (done_take) begin
                result <= conv_result;
            end
        end
    end

    // Acquisition timer restarts whenever the band gap channel is newly chosen.
    // It only advises software; the start is not held off, as timing is software's duty.
    always @(posedge clk) begin
        if (!rstn) begin
            acq_count <= 8'h00;
            acq_ready <= 1'b0;
        end else if (!dec_bgap || (ctrl_we && wr_chs != input_channel_select)) begin
            acq_count <= 8'h00;
            acq_ready <= 1'b0;
        end else if (acq_count != ACQ_CYCLES) begin
            acq_count <= acq_count + 8'h01;
            acq_ready <= 1'b0;
        end else begin
            acq_ready <= 1'b1;
        end
    end

    // Analog side outputs are registered; switches stay open while power is off.
    always @(posedge clk) begin
        if (!rstn) begin
            converter_enable <= 1'b0;
            ain_switch       <= {`ACS_EXT_INPUTS{1'b0}};
            temp_diode_sel   <= 1'b0;
            core_rail_sel    <= 1'b0;
            bandgap_sel      <= 1'b0;
            mux_open         <= 1'b1;
            chan_unimpl      <= 1'b0;
        end else begin
            converter_enable <= converter_power_on;
            ain_switch       <= converter_power_on ? dec_ext : {`ACS_EXT_INPUTS{1'b0}};
            temp_diode_sel   <= converter_power_on && dec_temp;
            core_rail_sel    <= converter_power_on && dec_core;
            bandgap_sel      <= converter_power_on && dec_bgap;
            mux_open         <= !converter_power_on || dec_open;
            chan_unimpl      <= dec_unimpl;
        end
    end

    // Interrupt status and mask.
    acs_irq_regs u_irq (
        .clk       (clk),
        .rstn      (rstn),
        .events    (events),
        .status_we (status_we),
        .mask_we   (mask_we),
        .wdata     (wr_data[`ACS_EV_WIDTH-1:0]),
        .status    (irq_status),
        .mask      (irq_mask),
        .irq       (irq_level)
    );

    // Read multiplexer; unmapped addresses read zero.
    always @* begin
        next_rd_data = 32'h0000_0000;
        case (addr)
            `ACS_OFS_CTRL:   next_rd_data = {24'h00_0000, ctrl_read};
            `ACS_OFS_STATUS: next_rd_data = {30'h0000_0000, irq_status};
            `ACS_OFS_MASK:   next_rd_data = {30'h0000_0000, irq_mask};
            `ACS_OFS_RESULT: next_rd_data = {20'h0_0000, result};
            `ACS_OFS_INFO:   next_rd_data = {28'h000_0000, result_unpredictable, go_flag, small_pkg, acq_ready};
            default:         next_rd_data = 32'h0000_0000;
        endcase
    end

    // Read data stand only in the cycle after the strobe; the irq output is re-registered.
    always @(posedge clk) begin
        if (!rstn) begin
            rd_data <= 32'h0000_0000;
            irq     <= 1'b0;
        end else begin
            rd_data <= rd_en ? next_rd_data : 32'h0000_0000;
            irq     <= irq_level;
        end
    end

endmodule // acs_channel_ctrl
`default_nettype wire

//--- acs_channel_ctrl_checker.sv
// Purpose: Concurrent checks on the ports of the converter channel control.
// Assumes: One clock domain; synchronous active-low reset; register map from acs_map.vh.
// Notes: A one-cycle delayed copy of each control write ties the outputs to the written code.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"

module acs_channel_ctrl_checker (
    input wire                         clk,              // System clock.
    input wire                         rstn,             // Synchronous reset, active low.
    input wire [7:0]                   addr,             // Register byte address.
    input wire [31:0]                  wr_data,          // Write data.
    input wire                         wr_en,            // Write strobe.
    input wire                         rd_en,            // Read strobe.
    input wire [31:0]                  rd_data,          // Read data.
    input wire                         small_pkg_pin,    // Package strap.
    input wire                         conv_done,        // Core done pulse.
    input wire [`ACS_RESULT_WIDTH-1:0] conv_result,      // Core result.
    input wire                         conv_start,       // Start pulse.
    input wire                         converter_enable, // Core power enable.
    input wire [`ACS_EXT_INPUTS-1:0]   ain_switch,       // External switches.
    input wire                         temp_diode_sel,   // Temperature diode switch.
    input wire                         core_rail_sel,    // Core rail switch.
    input wire                         bandgap_sel,      // Band gap switch.
    input wire                         mux_open,         // All switches open.
    input wire                         chan_unimpl,      // Channel not implemented.
    input wire                         irq               // Level interrupt.
);
    reg                        ctl_wr;
    reg  [7:0]                 wd;
    wire [4:0]                 wcode;
    wire [`ACS_EXT_INPUTS-1:0] ext_exp;

    // Delayed copy of a control write; the registered outputs show it one cycle later still.
    always @(posedge clk) begin
        if (!rstn) begin
            ctl_wr <= 1'b0;
            wd     <= 8'h00;
        end else begin
            ctl_wr <= wr_en && (addr == `ACS_OFS_CTRL);
            wd     <= wr_data[7:0];
        end
    end

    // Expected one-hot switch pattern for an external code.
    assign wcode   = wd[6:2];
    assign ext_exp = 11'h001 << wcode;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    top_bit_zero_a: assert property (
        $past(rd_en) && $past(addr) == `ACS_OFS_CTRL |-> rd_data[31:7] == 25'h0000000)
        else $error("control read shows upper bits set");
    start_one_cycle_a: assert property (conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");
    start_cause_a: assert property (
        $rose(conv_start) |-> ctl_wr && wd[1:0] == 2'h3)
        else $error("start pulse without a powered go write");
    start_powered_a: assert property (conv_start |=> converter_enable)
        else $error("start pulse while converter is off");
    power_follow_a: assert property (ctl_wr |=> converter_enable == $past(wd[0]))
        else $error("converter enable does not follow the power bit");
    off_all_open_a: assert property (
        !converter_enable |-> mux_open && ain_switch == 11'h000 && !temp_diode_sel && !core_rail_sel && !bandgap_sel)
        else $error("switch closed while converter is off");
    ext_route_a: assert property (
        ctl_wr && wd[0] && wcode <= 5'h0a && !(wcode >= 5'h05 && wcode <= 5'h07)
        |=> ain_switch == $past(ext_exp) && !mux_open && !chan_unimpl)
        else $error("external input not routed");
    reserved_none_a: assert property (
        ctl_wr && wcode > 5'h0a && wcode < 5'h1c |=> chan_unimpl && ain_switch == 11'h000 && !bandgap_sel)
        else $error("reserved code routes an input");
    disconnect_open_a: assert property (
        ctl_wr && wd[0] && wcode == 5'h1c
        |=> mux_open && ain_switch == 11'h000 && !temp_diode_sel && !core_rail_sel && !bandgap_sel)
        else $error("disconnect code leaves a switch closed");
    internal_sel_a: assert property (
        ctl_wr && wd[0] && wcode >= 5'h1d
        |=> {temp_diode_sel, core_rail_sel, bandgap_sel} == (3'h4 >> ($past(wcode) - 5'h1d)))
        else $error("internal channel switch wrong");

    // Main scenarios reached.
    cover property ($rose(conv_start));
    cover property (conv_done ##2 irq);
    cover property (ctl_wr && wd[0] && wcode == 5'h1c);
    cover property (ctl_wr && wd[1:0] == 2'h2);
endmodule // acs_channel_ctrl_checker

bind acs_channel_ctrl acs_channel_ctrl_checker acs_channel_ctrl_checker_i (
    .clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .small_pkg_pin(small_pkg_pin), .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
    .converter_enable(converter_enable), .ain_switch(ain_switch), .temp_diode_sel(temp_diode_sel),
    .core_rail_sel(core_rail_sel), .bandgap_sel(bandgap_sel), .mux_open(mux_open), .chan_unimpl(chan_unimpl),
    .irq(irq));
`default_nettype wire

//--- acs_channel_ctrl_tb.sv
// Purpose: Self-checking bench for the converter channel control through its register port.
// Assumes: The bench plays both software and the converter core; 10 MHz clock.
// Notes: Every output compare uses case inequality so an unknown never passes.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"

module acs_channel_ctrl_tb;
    logic                         clk;
    logic                         rstn;
    logic [7:0]                   addr;
    logic [31:0]                  wr_data;
    logic                         wr_en;
    logic                         rd_en;
    logic                         small_pkg_pin;
    logic                         conv_done;
    logic [`ACS_RESULT_WIDTH-1:0] conv_result;
    wire  [31:0]                  rd_data;
    wire                          conv_start;
    wire                          converter_enable;
    wire  [`ACS_EXT_INPUTS-1:0]   ain_switch;
    wire                          temp_diode_sel;
    wire                          core_rail_sel;
    wire                          bandgap_sel;
    wire                          mux_open;
    wire                          chan_unimpl;
    wire                          irq;
    int                           err_count;
    int                           checks_done;
    int                           c;
    logic [31:0]                  v;

    acs_channel_ctrl acs_channel_ctrl_i (
        .clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .small_pkg_pin(small_pkg_pin), .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
        .converter_enable(converter_enable), .ain_switch(ain_switch), .temp_diode_sel(temp_diode_sel),
        .core_rail_sel(core_rail_sel), .bandgap_sel(bandgap_sel), .mux_open(mux_open),
        .chan_unimpl(chan_unimpl), .irq(irq));

    // 100 ns period.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write strobe; the slave never stalls.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    // Core side: one-cycle done pulse with the result beside it.
    task automatic done(input logic [11:0] r);
        @(posedge clk);
        conv_done   <= 1'b1;
        conv_result <= r;
        @(posedge clk);
        conv_done <= 1'b0;
    endtask

    // Routing expected for a code with power on, packed as the outputs are below.
    function automatic logic [15:0] route_exp(input logic [4:0] k, input logic sp);
        logic gone;
        gone = (k > 5'h0a && k < 5'h1c) || (sp && k >= 5'h05 && k <= 5'h07);
        route_exp = {(k <= 5'h0a && !gone) ? (11'h001 << k) : 11'h000,
                     k == 5'h1d, k == 5'h1e, k == 5'h1f, k == 5'h1c, gone};
    endfunction

    task automatic route_check(input logic [4:0] k, input logic sp);
        wr(`ACS_OFS_CTRL, {25'h0000000, k, 2'h1});
        @(posedge clk);
        #1;
        chk("route", {ain_switch, temp_diode_sel, core_rail_sel, bandgap_sel, mux_open, chan_unimpl},
            {16'h0000, route_exp(k, sp)});
    endtask

    task automatic give_verdict;
        $display("Checks done: %0d, mismatches: %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        give_verdict();
    end

    initial begin
        {rstn, wr_en, rd_en, small_pkg_pin, conv_done} = 5'h00;
        addr = 8'h00;
        wr_data = 32'h00000000;
        conv_result = 12'h000;
        err_count = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("mux_open reset", mux_open, 32'h1);
        rd(`ACS_OFS_CTRL, v); chk("ctrl reset", v, 32'h0);
        rd(`ACS_OFS_STATUS, v); chk("status reset", v, 32'h0);
        rd(`ACS_OFS_MASK, v); chk("mask reset", v, 32'h0);
        rd(`ACS_OFS_RESULT, v); chk("result reset", v, 32'h0);
        wr(8'h14, 32'hffffffff);
        rd(8'h14, v); chk("unmapped", v, 32'h0);
        // Top bit ignored; power off keeps every switch open.
        wr(`ACS_OFS_CTRL, 32'h000000fc);
        rd(`ACS_OFS_CTRL, v); chk("ctrl top bit", v, 32'h7c);
        chk("off open", {mux_open, bandgap_sel}, 32'h2);
        for (c = 0; c < 32; c++) route_check(c[4:0], 1'b0);
        small_pkg_pin <= 1'b1;
        repeat (4) @(posedge clk);
        for (c = 5; c < 8; c++) route_check(c[4:0], 1'b1);
        small_pkg_pin <= 1'b0;
        repeat (4) @(posedge clk);
        // Go without power starts nothing.
        wr(`ACS_OFS_CTRL, 32'h00000002);
        rd(`ACS_OFS_CTRL, v); chk("go unpowered", v, 32'h0);
        // Conversion with the done interrupt unmasked; a second go while busy is refused.
        wr(`ACS_OFS_MASK, 32'h1);
        wr(`ACS_OFS_CTRL, 32'h0000000f);
        #1 chk("start", conv_start, 32'h1);
        rd(`ACS_OFS_CTRL, v); chk("go busy", v, 32'h0f);
        wr(`ACS_OFS_CTRL, 32'h0000000f);
        #1 chk("no restart", conv_start, 32'h0);
        done(12'h5a5);
        rd(`ACS_OFS_CTRL, v); chk("go cleared", v, 32'h0d);
        rd(`ACS_OFS_RESULT, v); chk("result", v, 32'h5a5);
        rd(`ACS_OFS_STATUS, v); chk("status done", v, 32'h1);
        chk("irq set", irq, 32'h1);
        wr(`ACS_OFS_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        #1 chk("irq cleared", irq, 32'h0);
        // Masked event stays pending until the mask opens.
        wr(`ACS_OFS_MASK, 32'h0);
        wr(`ACS_OFS_CTRL, 32'h0000000f);
        done(12'h00a);
        repeat (3) @(posedge clk);
        #1 chk("irq masked", irq, 32'h0);
        wr(`ACS_OFS_MASK, 32'h1);
        repeat (2) @(posedge clk);
        #1 chk("irq unmasked", irq, 32'h1);
        wr(`ACS_OFS_STATUS, 32'h1);
        // Start on a reserved code flags it and still takes the core result.
        wr(`ACS_OFS_CTRL, 32'h0000002f);
        done(12'h123);
        rd(`ACS_OFS_STATUS, v); chk("status reserved", v, 32'h3);
        rd(`ACS_OFS_RESULT, v); chk("result reserved", v, 32'h123);
        rd(`ACS_OFS_INFO, v); chk("info unpredictable", v[3], 32'h1);
        wr(`ACS_OFS_STATUS, 32'h3);
        // Power removed mid-conversion abandons it; the late done is ignored.
        wr(`ACS_OFS_CTRL, 32'h0000000f);
        wr(`ACS_OFS_CTRL, 32'h0000000c);
        rd(`ACS_OFS_CTRL, v); chk("abort", v, 32'h0c);
        chk("enable off", converter_enable, 32'h0);
        done(12'h777);
        rd(`ACS_OFS_STATUS, v); chk("late done", v, 32'h0);
        rd(`ACS_OFS_RESULT, v); chk("result kept", v, 32'h123);
        // Band gap acquisition time of 150 cycles; the band gap channel is selected here with power on.
        wr(`ACS_OFS_CTRL, 32'h0000007d);
        repeat (130) @(posedge clk);
        rd(`ACS_OFS_INFO, v); chk("acq early", v[0], 32'h0);
        repeat (30) @(posedge clk);
        rd(`ACS_OFS_INFO, v); chk("acq ready", v[0], 32'h1);
        give_verdict();
    end
endmodule // acs_channel_ctrl_tb
`default_nettype wire

//--- acs_irq_regs.v
// Purpose: Sticky interrupt status, mask and the level interrupt output.
// Assumes: Events are one-cycle pulses on the system clock.
// Notes: A status bit is cleared by writing one; a new event in that cycle wins.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"

module acs_irq_regs (
    input  wire                     clk,         // System clock.
    input  wire                     rstn,        // Synchronous reset, active low.
    input  wire [`ACS_EV_WIDTH-1:0] events,      // Event pulses.
    input  wire                     status_we,   // Write-one-to-clear strobe.
    input  wire                     mask_we,     // Mask write strobe.
    input  wire [`ACS_EV_WIDTH-1:0] wdata,       // Write data.
    output reg  [`ACS_EV_WIDTH-1:0] status,      // Sticky status bits.
    output reg  [`ACS_EV_WIDTH-1:0] mask,        // Interrupt enables.
    output reg                      irq          // Level interrupt.
);

    wire [`ACS_EV_WIDTH-1:0] next_status;

    // Set has priority over clear so that an event is never lost.
    assign next_status = (status & ~(status_we ? wdata : {`ACS_EV_WIDTH{1'b0}})) | events;

    // The interrupt is registered from next_status at the same edge as status so the output is glitch free.
    always @(posedge clk) begin
        if (!rstn) begin
            status <= `ACS_STATUS_RESET;
            mask   <= `ACS_MASK_RESET;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            if (mask_we) begin
                mask <= wdata;
            end
            irq <= |(next_status & (mask_we ? wdata : mask));
        end
    end

endmodule // acs_irq_regs
`default_nettype wire

//--- acs_map.vh
// Purpose: Register offsets, field positions, channel codes and timing counts for the converter channel control.
// Assumes: 10 MHz system clock, word-aligned registers on a plain strobe port.
// Notes: Included by every design file of the block.
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// Register byte offsets.
`define ACS_OFS_CTRL        8'h00
`define ACS_OFS_STATUS      8'h04
`define ACS_OFS_MASK        8'h08
`define ACS_OFS_RESULT      8'h0c
`define ACS_OFS_INFO        8'h10

// Control register field positions.
`define ACS_CTRL_UNIMPL_BIT 7
`define ACS_CTRL_CHS_HI     6
`define ACS_CTRL_CHS_LO     2
`define ACS_CTRL_GO_BIT     1
`define ACS_CTRL_ON_BIT     0

// Reset values.
`define ACS_CTRL_RESET      8'h00
`define ACS_CHS_RESET       5'h00
`define ACS_STATUS_RESET    2'h0
`define ACS_MASK_RESET      2'h0
`define ACS_RESULT_RESET    12'h000

// Interrupt status and mask bit positions.
`define ACS_EV_DONE_BIT     0
`define ACS_EV_BADCH_BIT    1
`define ACS_EV_WIDTH        2

// Information register bit positions.
`define ACS_INFO_ACQ_BIT    0
`define ACS_INFO_SMALL_BIT  1
`define ACS_INFO_BUSY_BIT   2

// Channel codes.
`define ACS_CH_EXT_LAST     5'h0a
`define ACS_CH_SMALL_FIRST  5'h05
`define ACS_CH_SMALL_LAST   5'h07
`define ACS_CH_DISCONNECT   5'h1c
`define ACS_CH_TEMP         5'h1d
`define ACS_CH_CORE         5'h1e
`define ACS_CH_BANDGAP      5'h1f

// Widths.
`define ACS_EXT_INPUTS      11
`define ACS_RESULT_WIDTH    12

// Timing: least acquisition time for the band gap channel, rounded up to clocks.
`define ACS_CLK_MHZ         10
`define ACS_ACQ_TIME_NS     15000
`define ACS_ACQ_CYCLES      ((`ACS_ACQ_TIME_NS * `ACS_CLK_MHZ + 999) / 1000)

`endif
